// >>> scuir_pkg.sv
// package: constants and carrier types of the smart card uart status/irq block
package scuir_pkg;
	// special function register addresses
	localparam logic [7:0] ADDR_BUF = 8'hAA;
	localparam logic [7:0] ADDR_STATUS = 8'hAD;
	localparam logic [7:0] ADDR_IRQ = 8'hAE;
	// bit positions, shared by status, identification and enable registers
	localparam int BIT_TBE = 7;
	localparam int BIT_CARD = 6;
	localparam int BIT_OVF = 5;
	localparam int BIT_VOLT = 4;
	localparam int BIT_WTO = 3;
	localparam int BIT_TX = 2;
	localparam int BIT_RX = 1;
	localparam int BIT_PAR = 0;
	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h80;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// implemented bits of identification and enable registers
	localparam logic [7:0] IRQ_MASK = 8'hBF;
	// synchroniser depth for pin levels
	localparam int SYNC_STAGES = 2;

	// events from the uart, counters and reset logic, same clock
	typedef struct packed {
		logic tx_load;
		logic tx_done;
		logic rx_done;
		logic char_err;
		logic last_rep;
		logic wt_expire;
		logic wt_reload;
		logic if_reset;
	} scuir_evt_type;

	// cpu special function register access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scuir_sfr_type;
endpackage : scuir_pkg

// >>> scuir_top.sv
// status and interrupt identification flags of the smart card uart
`timescale 1ns/1ps
`default_nettype none

module scuir_top (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// cpu special function register access
	input wire scuir_pkg::scuir_sfr_type sfr_in,
	input wire logic bank_select_in,
	output logic [7:0] sfr_rdata_out,
	// uart, counter and interface events
	input wire scuir_pkg::scuir_evt_type evt_in,
	input wire logic repetition_mode_in,
	// analog comparators and card detect, asynchronous levels
	input wire logic current_over_in,
	input wire logic voltage_ok_in,
	input wire logic card_present_in,
	// interrupt request and its highest priority source
	output logic irq_out,
	output logic [7:0] irq_source_out
);
	import scuir_pkg::*;

	// highest set bit wins: tbe, ovf, volt, wto, tx, rx, parity
	function automatic logic [7:0] prio_pick(input logic [7:0] vec);
		logic [7:0] pick;
		pick = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (vec[i]) begin
				pick = 8'h00;
				pick[i] = 1'b1;
			end
		end
		return pick;
	endfunction : prio_pick

	// synchroniser and edge history state
	logic [SYNC_STAGES-1:0] ovf_sync_r;
	logic [SYNC_STAGES-1:0] ovf_sync_nxt;
	logic [SYNC_STAGES-1:0] vok_sync_r;
	logic [SYNC_STAGES-1:0] vok_sync_nxt;
	logic [SYNC_STAGES-1:0] card_sync_r;
	logic [SYNC_STAGES-1:0] card_sync_nxt;
	logic ovf_last_r;
	logic ovf_last_nxt;
	logic vok_last_r;
	logic vok_last_nxt;

	// register state
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] flag_r;
	logic [7:0] flag_nxt;
	logic [7:0] en_r;
	logic [7:0] en_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic irq_r;
	logic irq_nxt;
	logic [7:0] src_r;
	logic [7:0] src_nxt;

	// decoded accesses and qualified events
	logic rd_status;
	logic rd_iir;
	logic wr_en;
	logic rd_buf;
	logic wr_buf;
	logic ovf_lvl;
	logic vok_lvl;
	logic ovf_rise;
	logic vok_fall;
	logic tx_set;
	logic rx_set;
	logic par_set;
	logic [7:0] flag_set;

	assign rd_status = sfr_in.rd && sfr_in.addr == ADDR_STATUS && !bank_select_in;
	assign rd_iir = sfr_in.rd && sfr_in.addr == ADDR_IRQ && !bank_select_in;
	assign wr_en = sfr_in.wr && sfr_in.addr == ADDR_IRQ && bank_select_in;
	assign rd_buf = sfr_in.rd && sfr_in.addr == ADDR_BUF;
	assign wr_buf = sfr_in.wr && sfr_in.addr == ADDR_BUF;

	assign ovf_lvl = ovf_sync_r[SYNC_STAGES-1];
	assign vok_lvl = vok_sync_r[SYNC_STAGES-1];
	assign ovf_rise = ovf_lvl && !ovf_last_r;
	assign vok_fall = !vok_lvl && vok_last_r;

	// in repetition mode only the final outcome counts
	assign tx_set = evt_in.tx_done && (!repetition_mode_in || !evt_in.char_err);
	assign rx_set = evt_in.rx_done &&
		(!repetition_mode_in || !evt_in.char_err || evt_in.last_rep);
	assign par_set = evt_in.char_err && (repetition_mode_in ?
		((evt_in.tx_done || evt_in.rx_done) && evt_in.last_rep) :
		evt_in.rx_done);

	always_comb begin
		flag_set = 8'h00;
		flag_set[BIT_TBE] = evt_in.tx_load;
		flag_set[BIT_OVF] = ovf_rise;
		flag_set[BIT_VOLT] = vok_fall;
		flag_set[BIT_WTO] = evt_in.wt_expire;
		flag_set[BIT_TX] = evt_in.tx_done && !(repetition_mode_in &&
			evt_in.char_err && !evt_in.last_rep);
		flag_set[BIT_RX] = rx_set;
		flag_set[BIT_PAR] = par_set;
	end

	// synchronisers: first stage read only by the second
	always_comb begin
		ovf_sync_nxt = {ovf_sync_r[SYNC_STAGES-2:0], current_over_in};
		vok_sync_nxt = {vok_sync_r[SYNC_STAGES-2:0], voltage_ok_in};
		card_sync_nxt = {card_sync_r[SYNC_STAGES-2:0], card_present_in};
		ovf_last_nxt = ovf_lvl;
		vok_last_nxt = vok_lvl;
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ovf_sync_r <= '0;
			vok_sync_r <= '0;
			card_sync_r <= '0;
			ovf_last_r <= 1'b0;
			vok_last_r <= 1'b0;
		end else if (ce_in) begin
			ovf_sync_r <= ovf_sync_nxt;
			vok_sync_r <= vok_sync_nxt;
			card_sync_r <= card_sync_nxt;
			ovf_last_r <= ovf_last_nxt;
			vok_last_r <= vok_last_nxt;
		end
	end

	// status register; hardware set wins over read clear
	always_comb begin
		status_nxt = status_r;
		status_nxt[BIT_OVF] = ovf_lvl;
		status_nxt[BIT_VOLT] = vok_lvl;
		status_nxt[BIT_CARD] = card_sync_r[SYNC_STAGES-1];
		if (evt_in.if_reset) begin
			status_nxt[BIT_WTO] = 1'b0;
		end else if (evt_in.wt_expire) begin
			status_nxt[BIT_WTO] = 1'b1;
		end else if (evt_in.wt_reload) begin
			status_nxt[BIT_WTO] = 1'b0;
		end
		if (rd_status) begin
			status_nxt[BIT_TX] = 1'b0;
			status_nxt[BIT_PAR] = 1'b0;
		end
		if (rd_buf) begin
			status_nxt[BIT_RX] = 1'b0;
		end
		if (wr_buf) begin
			status_nxt[BIT_TBE] = 1'b0;
		end
		if (evt_in.tx_load) begin
			status_nxt[BIT_TBE] = 1'b1;
		end
		if (tx_set) begin
			status_nxt[BIT_TX] = 1'b1;
		end
		if (rx_set) begin
			status_nxt[BIT_RX] = 1'b1;
		end
		if (par_set) begin
			status_nxt[BIT_PAR] = 1'b1;
		end
	end

	// identification flags, enables, read data and request
	always_comb begin
		flag_nxt = rd_iir ? FLAG_RESET : flag_r;
		flag_nxt = flag_nxt | flag_set;
		en_nxt = wr_en ? (sfr_in.wdata & IRQ_MASK) : en_r;
		rdata_nxt = rdata_r;
		if (rd_iir) begin
			rdata_nxt = flag_r & IRQ_MASK;
		end else if (sfr_in.rd && sfr_in.addr == ADDR_IRQ) begin
			rdata_nxt = en_r;
		end else if (rd_status) begin
			rdata_nxt = status_r;
		end
		irq_nxt = |(flag_r & en_r);
		src_nxt = prio_pick(flag_r & en_r);
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			status_r <= STATUS_RESET;
			flag_r <= FLAG_RESET;
			en_r <= ENABLE_RESET;
			rdata_r <= DATA_RESET;
			irq_r <= 1'b0;
			src_r <= 8'h00;
		end else if (ce_in) begin
			status_r <= status_nxt;
			flag_r <= flag_nxt;
			en_r <= en_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			src_r <= src_nxt;
		end
	end

	assign sfr_rdata_out = rdata_r;
	assign irq_out = irq_r;
	assign irq_source_out = src_r;

	// checks
	default clocking cb @(posedge clk_in);
	endclocking

	sequence s_ovf_high;
		(ce_in && current_over_in)[*3];
	endsequence

	sequence s_vok_high;
		(ce_in && voltage_ok_in && !rd_iir)[*3];
	endsequence

	sequence s_vok_low;
		(ce_in && !voltage_ok_in && !rd_iir)[*3];
	endsequence

	a_status_reset_value: assert property (
		!rstn_in |=> status_r[BIT_TBE] && status_r[5:0] == 6'h00)
		else $error("status not at reset value after reset");

	a_tbe_load_sets: assert property (
		disable iff (!rstn_in)
		ce_in && evt_in.tx_load |=> status_r[BIT_TBE] && flag_r[BIT_TBE])
		else $error("buffer load did not set empty status and flag");

	a_tbe_write_clears: assert property (
		disable iff (!rstn_in)
		ce_in && wr_buf && !evt_in.tx_load |=> !status_r[BIT_TBE])
		else $error("buffer write did not clear empty status");

	a_ovf_follows: assert property (
		disable iff (!rstn_in)
		s_ovf_high |=> status_r[BIT_OVF])
		else $error("overflow status does not follow comparator");

	a_volt_error_edge: assert property (
		disable iff (!rstn_in)
		s_vok_high ##1 s_vok_low |=> flag_r[BIT_VOLT] && !status_r[BIT_VOLT])
		else $error("voltage loss did not set error flag");

	a_iir_read_clears: assert property (
		disable iff (!rstn_in)
		ce_in && rd_iir && flag_set == 8'h00 |=> flag_r == 8'h00)
		else $error("identification read did not clear flags");

	a_iir_read_data: assert property (
		disable iff (!rstn_in)
		ce_in && rd_iir |=> sfr_rdata_out == ($past(flag_r) & IRQ_MASK))
		else $error("identification read returned wrong data");

	a_irq_masked: assert property (
		disable iff (!rstn_in)
		ce_in && en_r == 8'h00 |=> !irq_out)
		else $error("request raised with all enables clear");

	a_irq_raised: assert property (
		disable iff (!rstn_in)
		ce_in && (flag_r & en_r) != 8'h00 |=> irq_out ##0 $onehot(irq_source_out))
		else $error("enabled flag gave no request");

	a_tx_rep_fail: assert property (
		disable iff (!rstn_in)
		ce_in && evt_in.tx_done && repetition_mode_in && evt_in.char_err &&
			!status_r[BIT_TX] |=> !status_r[BIT_TX])
		else $error("failed repetition set transmitted status");

	a_parity_pair: assert property (
		disable iff (!rstn_in)
		ce_in && evt_in.rx_done && evt_in.char_err && !repetition_mode_in
			|=> status_r[BIT_PAR] && flag_r[BIT_PAR] && flag_r[BIT_RX])
		else $error("parity error not flagged with reception");

	a_wto_cycle: assert property (
		disable iff (!rstn_in)
		ce_in && evt_in.wt_expire && !evt_in.if_reset
			|=> status_r[BIT_WTO] && flag_r[BIT_WTO])
		else $error("timeout not recorded");

	a_wto_reload: assert property (
		disable iff (!rstn_in)
		ce_in && evt_in.wt_reload && !evt_in.wt_expire |=> !status_r[BIT_WTO])
		else $error("reload did not clear timeout status");

	a_prio_top: assert property (
		disable iff (!rstn_in)
		ce_in && flag_r[BIT_TBE] && en_r[BIT_TBE] |=> irq_source_out[BIT_TBE])
		else $error("buffer empty not given top priority");
endmodule : scuir_top

`default_nettype wire

// >>> scuir_tb.sv
// self-checking testbench of the smart card uart status/irq block
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import scuir_pkg::*;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic ce_in = 1'b1;
	logic bank_select_in = 1'b0;
	logic repetition_mode_in = 1'b0;
	logic current_over_in = 1'b0;
	logic voltage_ok_in = 1'b0;
	logic card_present_in = 1'b0;
	scuir_sfr_type sfr_in = '0;
	scuir_evt_type evt_in = '0;
	logic [7:0] sfr_rdata_out;
	logic [7:0] irq_source_out;
	logic irq_out;
	int miscompares = 0;
	int compares = 0;

	scuir_top i_dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
		.sfr_in(sfr_in), .bank_select_in(bank_select_in),
		.sfr_rdata_out(sfr_rdata_out), .evt_in(evt_in),
		.repetition_mode_in(repetition_mode_in),
		.current_over_in(current_over_in), .voltage_ok_in(voltage_ok_in),
		.card_present_in(card_present_in), .irq_out(irq_out),
		.irq_source_out(irq_source_out)
	);

	always #5 clk_in = ~clk_in;

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one strobe cycle, held until the sampling edge
	task acc(input logic r, input logic w, input logic [7:0] a,
			input logic b, input logic [7:0] d);
		@(posedge clk_in);
		sfr_in <= {r, w, a, d};
		bank_select_in <= b;
		@(posedge clk_in);
		sfr_in <= '0;
		#1;
	endtask : acc

	task rdc(input string nm, input logic [7:0] a, input logic b,
			input logic [7:0] exp);
		acc(1'b1, 1'b0, a, b, 8'h00);
		chk(nm, sfr_rdata_out, exp);
	endtask : rdc

	task fire(input logic [7:0] e);
		@(posedge clk_in);
		evt_in <= scuir_evt_type'(e);
		@(posedge clk_in);
		evt_in <= '0;
	endtask : fire

	task irqc(input logic i, input logic [7:0] src);
		@(posedge clk_in);
		#1;
		chk("irq", {7'h00, irq_out}, {7'h00, i});
		chk("source", irq_source_out, src);
	endtask : irqc

	task t_reset;
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		rdc("enable", ADDR_IRQ, 1'b1, 8'h00);
		acc(1'b0, 1'b1, ADDR_IRQ, 1'b0, 8'hFF);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h00);
		acc(1'b0, 1'b1, ADDR_IRQ, 1'b1, 8'hFF);
		rdc("enable", ADDR_IRQ, 1'b1, 8'hBF);
	endtask : t_reset

	task t_txbuf;
		acc(1'b0, 1'b1, ADDR_BUF, 1'b0, 8'h5A);
		rdc("status", ADDR_STATUS, 1'b0, 8'h00);
		fire(8'h80);
		irqc(1'b1, 8'h80);
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h80);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h00);
		irqc(1'b0, 8'h00);
	endtask : t_txbuf

	task t_rx;
		fire(8'h30);
		irqc(1'b1, 8'h02);
		rdc("status", ADDR_STATUS, 1'b0, 8'h83);
		rdc("status", ADDR_STATUS, 1'b0, 8'h82);
		acc(1'b1, 1'b0, ADDR_BUF, 1'b0, 8'h00);
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h03);
	endtask : t_rx

	// repetition mode: failed attempts, last attempts, good attempt
	task t_rep;
		@(posedge clk_in);
		repetition_mode_in <= 1'b1;
		fire(8'h50);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h00);
		fire(8'h58);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h05);
		rdc("status", ADDR_STATUS, 1'b0, 8'h81);
		fire(8'h30);
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		fire(8'h38);
		rdc("status", ADDR_STATUS, 1'b0, 8'h83);
		acc(1'b1, 1'b0, ADDR_BUF, 1'b0, 8'h00);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h03);
		fire(8'h40);
		rdc("status", ADDR_STATUS, 1'b0, 8'h84);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h04);
		@(posedge clk_in);
		repetition_mode_in <= 1'b0;
	endtask : t_rep

	task t_timeout;
		fire(8'h04);
		irqc(1'b1, 8'h08);
		rdc("status", ADDR_STATUS, 1'b0, 8'h88);
		rdc("status", ADDR_STATUS, 1'b0, 8'h88);
		fire(8'h02);
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		fire(8'h04);
		fire(8'h01);
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h08);
	endtask : t_timeout

	// comparator levels pass a two-stage synchroniser
	task t_pins;
		@(posedge clk_in);
		current_over_in <= 1'b1;
		card_present_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		irqc(1'b1, 8'h20);
		rdc("status", ADDR_STATUS, 1'b0, 8'hE0);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h20);
		@(posedge clk_in);
		current_over_in <= 1'b0;
		voltage_ok_in <= 1'b1;
		repeat (6) @(posedge clk_in);
		rdc("status", ADDR_STATUS, 1'b0, 8'hD0);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h00);
		repeat (3) @(posedge clk_in);
		voltage_ok_in <= 1'b0;
		card_present_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h10);
	endtask : t_pins

	task t_prio;
		fire(8'h84);
		irqc(1'b1, 8'h80);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h88);
	endtask : t_prio

	task t_masked;
		acc(1'b0, 1'b1, ADDR_IRQ, 1'b1, 8'h00);
		fire(8'h20);
		irqc(1'b0, 8'h00);
		acc(1'b0, 1'b1, ADDR_IRQ, 1'b1, 8'h02);
		irqc(1'b1, 8'h02);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h02);
	endtask : t_masked

	// clock enable low: an event must leave no trace
	task t_freeze;
		@(posedge clk_in);
		ce_in <= 1'b0;
		fire(8'h40);
		ce_in <= 1'b1;
		rdc("status", ADDR_STATUS, 1'b0, 8'h8A);
		rdc("ident", ADDR_IRQ, 1'b0, 8'h00);
		irqc(1'b0, 8'h00);
	endtask : t_freeze

	// reset in mid-run returns registers to reset values
	task t_rerun;
		@(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		rdc("status", ADDR_STATUS, 1'b0, 8'h80);
		rdc("enable", ADDR_IRQ, 1'b1, 8'h00);
		irqc(1'b0, 8'h00);
	endtask : t_rerun

	task test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	initial begin
		#20000;
		miscompares++;
		test_done();
	end

	initial begin
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_reset();
		t_txbuf();
		t_rx();
		t_rep();
		t_timeout();
		t_pins();
		t_prio();
		t_masked();
		t_freeze();
		t_rerun();
		test_done();
	end
endmodule : testbench

`default_nettype wire
